/* File: verilog/eif_ext_irq.sv */
// Purpose: five external interrupt inputs with noise filters and latches
// Assumes: clk is the high-frequency clock; fs_tick pulses once per
//   low-frequency period; sfr strobes are one clk wide
// Notes: latch bit order is in0, in1, in3, in4, in5 (bits 0 to 4)
`timescale 1ns/1ps
module eif_ext_irq #(
	parameter int CNT_W = eif_pkg::FILT_CNT_W
) (
	input wire logic clk, // high-frequency clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic ext_irq_in0, // shared port pin, falling edge
	input wire logic ext_irq_in1, // input 1 pin
	input wire logic ext_irq_in3, // input 3 pin
	input wire logic ext_irq_in4, // input 4 pin
	input wire logic ext_irq_in5, // input 5 pin, falling edge
	input wire logic slow_mode, // slow or sleep mode active
	input wire logic fs_tick, // one pulse per low-frequency period
	input wire logic master_irq_enable, // global enable flag
	input wire logic [4:0] irq_enable_register, // per-input enable flags
	input wire logic [4:0] latch_clr, // latch clear pulses from cpu
	input wire logic [5:0] sfr_addr, // special register address
	input wire logic [7:0] sfr_wdata, // write data
	input wire logic sfr_wr, // write strobe
	input wire logic sfr_rd, // read strobe
	output logic [7:0] sfr_rdata, // read data, registered
	output logic [4:0] irq_latch, // interrupt latches
	output logic in0_pin_is_irq // shared pin acting as interrupt
);
	localparam int NIN = 5;

	logic [7:0] ext_irq_control_r;
	logic in1_noise_select;
	logic in0_pin_select;
	logic [1:0] in3_edge_field;
	logic [1:0] in4_edge_field;
	logic in1_edge_bit;
	logic sel_ctrl;

	logic [NIN-1:0] pins;
	logic [NIN-1:0] filt;
	logic [NIN-1:0] hit;
	logic [NIN-1:0] allow;
	logic [NIN-1:0] set_req;
	logic sample_tick;
	logic [CNT_W-1:0] len_fast [NIN];
	logic [CNT_W-1:0] len_sel [NIN];
	eif_pkg::eif_mode_type mode [NIN];

	// size a stable count to the counter width
	function automatic logic [CNT_W-1:0] cnt_of(input int n);
		cnt_of = CNT_W'(n);
	endfunction

	// register address decode
	assign sel_ctrl = (sfr_addr == eif_pkg::CTRL_ADDR);

	// control register; bit 0 is not stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_irq_control_r <= eif_pkg::CTRL_RESET;
		end else if (sfr_wr && sel_ctrl) begin
			ext_irq_control_r <= {sfr_wdata[7:1], 1'b0};
		end
	end

	// field extraction
	assign in1_noise_select = ext_irq_control_r[eif_pkg::NOISE_SEL_BIT];
	assign in0_pin_select = ext_irq_control_r[eif_pkg::PIN_SEL_BIT];
	assign in3_edge_field = ext_irq_control_r[eif_pkg::IN3_EDGE_HI:eif_pkg::IN3_EDGE_LO];
	assign in4_edge_field = ext_irq_control_r[eif_pkg::IN4_EDGE_HI:eif_pkg::IN4_EDGE_LO];
	assign in1_edge_bit = ext_irq_control_r[eif_pkg::IN1_EDGE_BIT];

	// read data, zero for other addresses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= sel_ctrl ? ext_irq_control_r : 8'h00;
		end
	end

	// shared pin is a general port until pin select is set
	assign in0_pin_is_irq = in0_pin_select;

	// pins in latch bit order
	assign pins = {ext_irq_in5, ext_irq_in4, ext_irq_in3, ext_irq_in1, ext_irq_in0};

	// sampling instant: every clk in fast modes, each fs period in slow
	assign sample_tick = slow_mode ? fs_tick : 1'b1;

	// fast-mode filter lengths per input
	always_comb begin
		len_fast[0] = cnt_of(eif_pkg::IN05_STABLE);
		len_fast[1] = in1_noise_select ? cnt_of(eif_pkg::IN1_SHORT_STABLE)
			: cnt_of(eif_pkg::IN1_LONG_STABLE);
		len_fast[2] = cnt_of(eif_pkg::IN34_STABLE);
		len_fast[3] = cnt_of(eif_pkg::IN34_STABLE);
		len_fast[4] = cnt_of(eif_pkg::IN05_STABLE);
	end

	// slow mode uses one shared length for all inputs
	always_comb begin
		for (int i = 0; i < NIN; i++) begin
			len_sel[i] = slow_mode ? cnt_of(eif_pkg::SLOW_STABLE) : len_fast[i];
		end
	end

	// trigger modes per input
	always_comb begin
		mode[0] = eif_pkg::EIF_FALL;
		mode[1] = in1_edge_bit ? eif_pkg::EIF_FALL : eif_pkg::EIF_RISE;
		mode[2] = eif_pkg::eif_mode_type'(in3_edge_field);
		mode[3] = eif_pkg::eif_mode_type'(in4_edge_field);
		mode[4] = eif_pkg::EIF_FALL;
	end

	// one filter and one detector per input
	for (genvar g = 0; g < NIN; g++) begin : g_in
		eif_noise_filter #(
			.CNT_W(CNT_W)
		) u_filt (
			.clk(clk),
			.rst_n(rst_n),
			.pin(pins[g]),
			.sample_tick(sample_tick),
			.stable_len(len_sel[g]),
			.filt(filt[g])
		);

		eif_edge_detect u_det (
			.clk(clk),
			.rst_n(rst_n),
			.filt(filt[g]),
			.mode(mode[g]),
			.hit(hit[g])
		);
	end

	// enable gating; input 0 also needs pin select
	always_comb begin
		allow = irq_enable_register & {NIN{master_irq_enable}};
		allow[0] = allow[0] & in0_pin_select;
	end

	assign set_req = hit & allow;

	// sticky latches, set beats clear, one cycle after detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_latch <= '0;
		end else begin
			irq_latch <= (irq_latch & ~latch_clr) | set_req;
		end
	end
endmodule

/* File: verilog/eif_pkg.sv */
// Purpose: constants shared by the external interrupt front end
// Assumes: clk is the high-frequency clock at 10 MHz
// Notes: filter figures are in clock periods of the sampling clock
package eif_pkg;

	// control register location and layout
	localparam logic [5:0] CTRL_ADDR = 6'h37;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int NOISE_SEL_BIT = 7;
	localparam int PIN_SEL_BIT = 6;
	localparam int IN3_EDGE_HI = 5;
	localparam int IN3_EDGE_LO = 4;
	localparam int IN4_EDGE_HI = 3;
	localparam int IN4_EDGE_LO = 2;
	localparam int IN1_EDGE_BIT = 1;

	// clock rate
	localparam int CLK_HZ = 10000000;
	localparam int FC_HZ = 10000000;

	// noise figures in high-frequency periods (reject below, accept at or above)
	localparam int IN05_REJECT_FC = 2;
	localparam int IN05_ACCEPT_FC = 7;
	localparam int IN34_REJECT_FC = 7;
	localparam int IN34_ACCEPT_FC = 25;
	localparam int IN1_LONG_REJECT_FC = 63;
	localparam int IN1_LONG_ACCEPT_FC = 193;
	localparam int IN1_SHORT_REJECT_FC = 15;
	localparam int IN1_SHORT_ACCEPT_FC = 49;
	// slow mode figures in low-frequency periods, 3.5 kept as tenths
	localparam int SLOW_REJECT_FS = 1;
	localparam int SLOW_ACCEPT_FS_X10 = 35;
	// longest wait for a noise select change, in high-frequency periods
	localparam int NOISE_SEL_SETTLE_FC = 64;

	// stable-sample counts chosen between reject and accept figures
	localparam int FC_TO_CLK = CLK_HZ / FC_HZ;
	localparam int IN05_STABLE = ((IN05_REJECT_FC + IN05_ACCEPT_FC) / 2) * FC_TO_CLK;
	localparam int IN34_STABLE = ((IN34_REJECT_FC + IN34_ACCEPT_FC) / 2) * FC_TO_CLK;
	localparam int IN1_LONG_STABLE =
		((IN1_LONG_REJECT_FC + IN1_LONG_ACCEPT_FC) / 2) * FC_TO_CLK;
	localparam int IN1_SHORT_STABLE =
		((IN1_SHORT_REJECT_FC + IN1_SHORT_ACCEPT_FC) / 2) * FC_TO_CLK;
	localparam int SLOW_STABLE = (SLOW_REJECT_FS * 10 + SLOW_ACCEPT_FS_X10) / 20;
	localparam int FILT_CNT_W = 8;
	// filtered level after reset: the idle high level of the pins
	localparam logic FILT_RESET = 1'b1;

	// trigger modes
	typedef enum logic [1:0] {
		EIF_RISE = 2'b00,
		EIF_FALL = 2'b01,
		EIF_BOTH = 2'b10,
		EIF_HIGH = 2'b11
	} eif_mode_type;

endpackage

/* File: verilog/eif_noise_filter.sv */
// Purpose: two-stage synchroniser and pulse-width noise filter for one pin
// Assumes: sample_tick marks each filter sampling instant
// Notes: output follows the pin only after stable_len agreeing samples
`timescale 1ns/1ps
module eif_noise_filter #(
	parameter int CNT_W = 8
) (
	input wire logic clk, // high-frequency clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic pin, // raw external pin
	input wire logic sample_tick, // sampling qualifier
	input wire logic [CNT_W-1:0] stable_len, // samples needed to accept
	output logic filt // filtered level, registered
);
	logic sync1_r;
	logic sync2_r;
	logic [CNT_W-1:0] cnt_r;

	// two flip-flop synchroniser; first stage feeds only the second
	// reset to the idle high level, matching the detector's previous level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= eif_pkg::FILT_RESET;
			sync2_r <= eif_pkg::FILT_RESET;
		end else begin
			sync1_r <= pin;
			sync2_r <= sync1_r;
		end
	end

	// count agreeing samples, drop short pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			filt <= eif_pkg::FILT_RESET; // no false edge after reset
		end else if (sync2_r == filt) begin
			cnt_r <= '0;
		end else if (sample_tick) begin
			if (cnt_r + 1'b1 >= stable_len) begin
				filt <= sync2_r;
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

/* File: verilog/eif_edge_detect.sv */
// Purpose: edge or level detection on one filtered input
// Assumes: filt comes from the noise filter of the same input
// Notes: level mode stays quiet until a rising edge after reset
`timescale 1ns/1ps
module eif_edge_detect (
	input wire logic clk, // high-frequency clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic filt, // filtered level
	input wire eif_pkg::eif_mode_type mode, // trigger mode
	output logic hit // request this cycle
);
	logic prev_r;
	logic armed_r;
	logic rise;
	logic fall;

	// previous level; reset high so a pin high at release is no edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= filt;
		end
	end

	assign rise = filt & ~prev_r;
	assign fall = ~filt & prev_r;

	// level mode armed only by a rising edge after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_r <= 1'b0;
		end else if (rise) begin
			armed_r <= 1'b1;
		end
	end

	// mode decode
	always_comb begin
		case (mode)
			eif_pkg::EIF_RISE: hit = rise;
			eif_pkg::EIF_FALL: hit = fall;
			eif_pkg::EIF_BOTH: hit = rise | fall;
			eif_pkg::EIF_HIGH: hit = filt & armed_r;
			default: hit = 1'b0;
		endcase
	end
endmodule

/* File: test/eif_pin_source.sv */
// Purpose: far-side source driving the five interrupt pins
// Assumes: pins change just after the rising clock edge
// Notes: a glitch flips one pin away from its resting level
`timescale 1ns/1ps
module eif_pin_source (
	input wire logic clk, // bench clock
	input wire logic [4:0] lvl, // resting pin levels
	input wire logic go, // start a glitch
	input wire logic [2:0] sel, // pin to disturb
	input wire logic [7:0] len, // glitch length in cycles
	output logic [4:0] pins // driven pin levels
);
	logic [7:0] left_r = 8'h00;
	logic [2:0] sel_r = 3'h0;
	// count the glitch down
	always @(posedge clk) begin
		if (go) begin
			left_r <= len;
			sel_r <= sel;
		end else if (left_r != 8'h00) begin
			left_r <= left_r - 8'h01;
		end
	end
	// flip the chosen pin while the glitch runs
	assign pins = lvl ^ ((left_r != 8'h00) ? 5'(5'h01 << sel_r) : 5'h00);
endmodule

/* File: test/eif_ext_irq_assertions.sv */
// Purpose: port checks for the external interrupt front end
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every front end instance
`timescale 1ns/1ps
module eif_ext_irq_assertions (
	input wire logic clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic ext_irq_in5, // input 5 pin
	input wire logic slow_mode, // slow sampling
	input wire logic master_irq_enable, // global enable
	input wire logic [4:0] irq_enable_register, // per-latch enables
	input wire logic [4:0] latch_clr, // clear pulses
	input wire logic [5:0] sfr_addr, // register address
	input wire logic [7:0] sfr_wdata, // write data
	input wire logic sfr_wr, // write strobe
	input wire logic sfr_rd, // read strobe
	input wire logic [7:0] sfr_rdata, // read data
	input wire logic [4:0] irq_latch, // latches
	input wire logic in0_pin_is_irq // shared pin role
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [4:0] keep_r;
	wire ctrl_wr = sfr_wr && sfr_addr == eif_pkg::CTRL_ADDR;
	// latches that must survive the next edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) keep_r <= 5'h00;
		else keep_r <= irq_latch & ~latch_clr;
	end
	chk_master_gate: assert property (
		|(irq_latch & ~$past(irq_latch)) |-> $past(master_irq_enable))
		else $error("latch set without master enable");
	chk_enable_gate: assert property (
		(irq_latch & ~$past(irq_latch) & ~$past(irq_enable_register)) == 5'h00)
		else $error("latch set without its enable");
	chk_latch_hold: assert property ((irq_latch & keep_r) == keep_r)
		else $error("latch dropped without clear");
	chk_in0_role: assert property ($rose(irq_latch[0]) |-> $past(in0_pin_is_irq))
		else $error("input 0 latch set in port role");
	chk_role_write: assert property (ctrl_wr |=> in0_pin_is_irq == $past(sfr_wdata[6]))
		else $error("pin role not taken from write");
	chk_role_hold: assert property (!ctrl_wr |=> $stable(in0_pin_is_irq))
		else $error("pin role changed without write");
	chk_unmapped_read: assert property (
		sfr_rd && sfr_addr != eif_pkg::CTRL_ADDR |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_bit0_zero: assert property (sfr_rd |=> !sfr_rdata[0])
		else $error("bit 0 read as one");
	chk_read_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	chk_in5_filter: assert property (
		$rose(irq_latch[4]) && !slow_mode |-> !$past(ext_irq_in5, 4) && !$past(ext_irq_in5, 5))
		else $error("input 5 latch set without a long low");
	cov_in5: cover property ($rose(irq_latch[4]));
	cov_in1: cover property ($rose(irq_latch[1]));
	cov_read: cover property (sfr_rd && sfr_addr == eif_pkg::CTRL_ADDR);
endmodule
bind eif_ext_irq eif_ext_irq_assertions eif_ext_irq_assertions_inst (.clk(clk), .rst_n(rst_n),
	.ext_irq_in5(ext_irq_in5), .slow_mode(slow_mode), .master_irq_enable(master_irq_enable),
	.irq_enable_register(irq_enable_register), .latch_clr(latch_clr), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.irq_latch(irq_latch), .in0_pin_is_irq(in0_pin_is_irq));

/* File: test/test_ext_irq_edge_noise_filter.sv */
// Purpose: self-checking bench for the external interrupt front end
// Assumes: 10 MHz clock, fs_tick every fourth cycle
// Notes: results are noted in a queue and matched by a monitor
`timescale 1ns/1ps
module test_ext_irq_edge_noise_filter;
	logic clk = 1'b0, rst_n = 1'b0, slow_mode = 1'b0, fs_tick = 1'b0, go = 1'b0;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, rd_seen = 1'b0, mie = 1'b1, role;
	logic [4:0] lvl = 5'h15, en = 5'h1f, clr = 5'h00, exp_l = 5'h00, pins, irq_latch, prev_l;
	logic [7:0] wdata = 8'h00, len = 8'h00, rdata, notes[$];
	logic [5:0] addr = 6'h00;
	logic [2:0] sel = 3'h0;
	logic [0:9] hit = 10'b1101111011, slw = 10'b0000000011;
	int pin[10] = '{4, 0, 0, 2, 3, 1, 1, 4, 4, 2};
	int ctl[10] = '{0, 8'h40, 0, 0, 0, 0, 8'h80, 0, 0, 0};
	int rej[10] = '{2, 2, 2, 7, 7, 63, 15, 2, 4, 4};
	int acc[10] = '{7, 7, 7, 25, 25, 193, 49, 7, 14, 14};
	int bad_count = 0, n_compared = 0, cycles = 0;
	eif_pin_source eif_pin_source_inst (.clk(clk), .lvl(lvl), .go(go), .sel(sel), .len(len),
		.pins(pins));
	eif_ext_irq eif_ext_irq_inst (.clk(clk), .rst_n(rst_n), .ext_irq_in0(pins[0]),
		.ext_irq_in1(pins[1]), .ext_irq_in3(pins[2]), .ext_irq_in4(pins[3]), .ext_irq_in5(pins[4]),
		.slow_mode(slow_mode), .fs_tick(fs_tick), .master_irq_enable(mie),
		.irq_enable_register(en), .latch_clr(clr), .sfr_addr(addr), .sfr_wdata(wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(rdata), .irq_latch(irq_latch),
		.in0_pin_is_irq(role));
	always #50 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] want);
		@(posedge clk);
		notes.push_back(want);
		addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
	endtask
	task automatic note_set(input int s);
		exp_l[s] = 1'b1;
		notes.push_back({3'h0, exp_l});
	endtask
	task automatic clear_l(input int s);
		if (exp_l[s]) begin
			exp_l[s] = 1'b0;
			notes.push_back({3'h0, exp_l});
		end
		@(posedge clk);
		clr[s] <= 1'b1;
		@(posedge clk);
		clr <= 5'h00;
	endtask
	task automatic pulse(input int s, input int n);
		@(posedge clk);
		sel <= s[2:0];
		len <= n[7:0];
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		tick(n + 60);
	endtask
	// cycle count, slow sampling ticks and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		fs_tick <= (cycles % 4 == 3);
		if (cycles == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	// match each read result and latch change against the oldest note
	always @(posedge clk) begin
		rd_seen <= sfr_rd;
		prev_l <= irq_latch;
		if (rst_n && (rd_seen || irq_latch !== prev_l)) begin
			if (notes.size() == 0) begin
				bad_count++;
				$display("unexpected at %0t: change with nothing noted", $time);
			end else check(rd_seen ? rdata : {3'h0, irq_latch}, notes.pop_front());
		end
	end
	// main sequence
	initial begin
		int s, m;
		void'($urandom(87583));
		tick(5);
		rst_n <= 1'b1;
		rd(eif_pkg::CTRL_ADDR, 8'h00);
		check({7'h00, role}, 8'h00);
		wr(eif_pkg::CTRL_ADDR, 8'h30);
		tick(60);
		lvl[2] <= 1'b0;
		// let input 1 settle low on its long filter before its mode turns falling
		tick(100);
		wr(eif_pkg::CTRL_ADDR, 8'hff);
		rd(eif_pkg::CTRL_ADDR, 8'hfe);
		check({7'h00, role}, 8'h01);
		wr(6'h38, 8'h00);
		rd(eif_pkg::CTRL_ADDR, 8'hfe);
		rd(6'h36, 8'h00);
		// step each edge mode up and down, control rewritten with pins at rest
		for (int k = 0; k < 10; k++) begin
			s = (k < 8) ? 2 + k / 4 : 1;
			m = (k < 8) ? k % 4 : k - 8;
			wr(eif_pkg::CTRL_ADDR, (k < 4) ? 8'(m << 4) : (k < 8) ? 8'(m << 2) : 8'(8'h80 | m << 1));
			tick(64);
			if (m != 1) note_set(s);
			lvl[s] <= 1'b1;
			tick(200);
			if (m != 3) clear_l(s);
			if (m == 1 || m == 2) note_set(s);
			lvl[s] <= 1'b0;
			tick(200);
			clear_l(s);
		end
		// short glitch then long pulse per pin, filter and mode
		for (int i = 0; i < 10; i++) begin
			// enables masked while control is rewritten
			en <= 5'h00;
			wr(eif_pkg::CTRL_ADDR, 8'(ctl[i]));
			en <= (i == 7) ? 5'h0f : 5'h1f;
			slow_mode <= slw[i];
			tick(64);
			pulse(pin[i], $urandom_range(rej[i] - 1, 1));
			if (hit[i]) note_set(pin[i]);
			pulse(pin[i], $urandom_range(acc[i] + 5, acc[i]));
			clear_l(pin[i]);
		end
		// master enable off: an accepted pulse must leave the latches alone
		mie <= 1'b0;
		pulse(4, 20);
		mie <= 1'b1;
		tick(20);
		check(8'(notes.size()), 8'h00);
		end_sim();
	end
endmodule
